// *** logic/ctz_top.sv ***
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`default_nettype none
// Notes on behaviour
// - cool/warm fold-back halves safety timer rate
// - temperature suspend: freeze timer, blink, phase 00
// - OTG outside window: suspend, codes, set flag
// - bypass suspended: power-good low, switch off
// - back to normal: restart OTG, zone 000
// - setting 00 suspends, 11 full, rate ignored
// - 20%/40% scaled by C-rate code
// - bias switch open when not measuring
// - bias short: open switch, zone 3, suspend
// - three timers, trickle fixed one hour
// - timer counts only when enabled and stage active
// - expiry sets indicator and latch
// - current reduction gives half rate if enabled
// - faults pause timers, resume from held value
// - no timers, no termination: charge until disabled
// - thermistor bypass: always valid, zone 000
module ctz_top #(
  parameter int HALF_SEC_CYC = ctz_pkg::CTZ_HALF_SEC_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire ctz_pkg::ctz_sense_type sense_in,
  input wire ctz_pkg::ctz_stage_type stage_in,
  input wire logic term_detect,
  input wire logic otg_ready,
  input wire logic pmid_in_range,
  input wire logic [2:0] adapter_source_code,
  output logic charge_on,
  output logic [9:0] current_permille,
  output logic boost_on,
  output logic high_side_switch,
  output logic accessory_power_good,
  output logic bias_switch_on,
  output logic stat_out,
  output logic stat_oe
);
  import ctz_pkg::*;

  ctz_sense_type sense;
  ctz_stage_type stage;
  logic [6:0] ctrl;
  logic [9:0] fold;
  logic [2:0] tlen;
  logic [1:0] charge_phase_code;
  logic [2:0] input_source_code;
  logic [2:0] temp_zone_code;
  logic temp_zone_flag;
  logic timer_expiry_latch;
  logic exp_prev;
  logic next_exp_prev;
  logic done;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] half_cnt;
  logic half_tick;
  logic sec_tick;
  logic blink;
  logic [6:0] next_ctrl;
  logic [9:0] next_fold;
  logic [2:0] next_tlen;
  logic [1:0] next_phase;
  logic [2:0] next_src;
  logic [2:0] next_zone;
  logic next_zflag;
  logic next_xflag;
  logic next_done;
  logic next_wr_pend;
  logic [7:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic [31:0] next_half_cnt;
  logic next_half_tick;
  logic next_sec_tick;
  logic next_blink;
  logic next_charge_on;
  logic [9:0] next_permille;
  logic next_boost_on;
  logic next_hss;
  logic next_apg;
  logic next_bias;
  logic next_stat_oe;
  logic [1:0] zone_setting;
  logic [9:0] fold_pm;
  logic ts_byp;
  logic short_fault;
  logic temp_suspend;
  logic chg_fault;
  logic reduced;
  logic otg_bad;
  logic otg_want;
  logic otg_suspend;
  logic chg_stage;
  logic any_expired;
  logic t_trk_exp;
  logic t_pre_exp;
  logic t_fast_exp;
  logic tmr_clear;
  logic tmr_half;
  logic [16:0] fast_len;
  logic [16:0] pre_len;
  logic addr_ok;
  logic rd_go;
  logic wr_go;
  logic [31:0] stat_word;

  // comparator zone taken as synchronous, one register stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense <= '{zone: CTZ_Z_NORMAL, default: 1'b0};
      stage <= CTZ_S_IDLE;
    end else if (ce) begin
      sense <= sense_in;
      stage <= stage_in;
    end
  end

  // zone qualification and fold-back selection
  always_comb begin
    ts_byp = ctrl[CTZ_CTRL_TS_BYP];
    short_fault = sense.bias_short && !ts_byp;
    case (sense.zone)
      CTZ_Z_PRECOOL: zone_setting = fold[CTZ_FOLD_PRECOOL +: 2];
      CTZ_Z_COOL: zone_setting = fold[CTZ_FOLD_COOL +: 2];
      CTZ_Z_PREWARM: zone_setting = fold[CTZ_FOLD_PREWARM +: 2];
      CTZ_Z_WARM: zone_setting = fold[CTZ_FOLD_WARM +: 2];
      CTZ_Z_COLD, CTZ_Z_HOT: zone_setting = CTZ_FB_SUSPEND;
      default: zone_setting = 2'h3;
    endcase
    if (ts_byp) begin
      zone_setting = 2'h3;
    end
  end

  ctz_foldback u_fold (
    .setting(zone_setting),
    .rate(fold[CTZ_FOLD_RATE +: 2]),
    .permille(fold_pm)
  );

  // charge and OTG qualification
  always_comb begin
    temp_suspend = (zone_setting == CTZ_FB_SUSPEND);
    chg_fault = temp_suspend || short_fault;
    reduced = (fold_pm != CTZ_PM_FULL) && !temp_suspend;
    chg_stage = (stage != CTZ_S_IDLE);
    otg_bad = !ts_byp && (sense.otg_cold || sense.otg_hot || sense.bias_short);
    otg_want = ctrl[CTZ_CTRL_OTG_EN] && otg_ready;
    otg_suspend = otg_want && otg_bad;
    any_expired = t_trk_exp || t_pre_exp || t_fast_exp;
    // expiry only stops charge while timers are on, otherwise runs on
    next_done = done;
    if (!ctrl[CTZ_CTRL_CHG_EN]) begin
      next_done = 1'b0;
    end else if (ctrl[CTZ_CTRL_TERM_EN] && term_detect && chg_stage) begin
      next_done = 1'b1;
    end
    next_charge_on = ctrl[CTZ_CTRL_CHG_EN] && chg_stage && !done && !chg_fault
      && !(ctrl[CTZ_CTRL_TMR_EN] && any_expired);
    next_permille = next_charge_on ? fold_pm : 10'h000;
    next_boost_on = otg_want && !otg_bad && !ctrl[CTZ_CTRL_BYP_EN];
    next_hss = otg_want && !otg_bad && ctrl[CTZ_CTRL_BYP_EN];
    next_apg = next_hss || (next_boost_on && pmid_in_range);
    next_bias = sense.measuring && !short_fault && !ts_byp;
  end

  // timer controls and lengths
  always_comb begin
    tmr_clear = !ctrl[CTZ_CTRL_CHG_EN] || done;
    tmr_half = ctrl[CTZ_CTRL_HALF_EN] && reduced;
    case (tlen[CTZ_TLEN_FAST +: 2])
      2'h0: fast_len = CTZ_FAST_SEC_0;
      2'h1: fast_len = CTZ_FAST_SEC_1;
      2'h2: fast_len = CTZ_FAST_SEC_2;
      default: fast_len = CTZ_FAST_SEC_3;
    endcase
    pre_len = tlen[CTZ_TLEN_PRE] ? CTZ_PRE_SEC_1 : CTZ_PRE_SEC_0;
  end

  // trickle, pre-charge and fast timers; paused while a fault holds
  ctz_timer u_trk (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .sec_tick(sec_tick),
    .run(ctrl[CTZ_CTRL_TMR_EN] && stage == CTZ_S_TRICKLE && !chg_fault),
    .half(tmr_half), .clear(tmr_clear),
    .length(17'(CTZ_TRICKLE_SEC)),
    .expired(t_trk_exp)
  );
  ctz_timer u_pre (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .sec_tick(sec_tick),
    .run(ctrl[CTZ_CTRL_TMR_EN] && stage == CTZ_S_PRE && !chg_fault),
    .half(tmr_half), .clear(tmr_clear), .length(pre_len),
    .expired(t_pre_exp)
  );
  ctz_timer u_fast (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .sec_tick(sec_tick),
    .run(ctrl[CTZ_CTRL_TMR_EN] && (stage == CTZ_S_FAST || stage == CTZ_S_CV)
      && !chg_fault),
    .half(tmr_half), .clear(tmr_clear), .length(fast_len),
    .expired(t_fast_exp)
  );

  // status codes, status pin, second tick and blink base
  always_comb begin
    next_half_cnt = half_cnt + 32'h00000001;
    next_half_tick = 1'b0;
    next_sec_tick = 1'b0;
    next_blink = blink;
    if (half_cnt >= 32'(HALF_SEC_CYC - 1)) begin
      next_half_cnt = '0;
      next_half_tick = 1'b1;
      next_blink = !blink;
      next_sec_tick = blink;
    end
    if (!charge_on) begin
      next_phase = 2'h0;
    end else if (stage == CTZ_S_CV) begin
      next_phase = 2'h2;
    end else if (stage == CTZ_S_TOPOFF) begin
      next_phase = 2'h3;
    end else begin
      next_phase = 2'h1;
    end
    if (otg_suspend) begin
      next_src = CTZ_SRC_NONE;
    end else if (boost_on || high_side_switch) begin
      next_src = CTZ_SRC_OTG;
    end else begin
      next_src = adapter_source_code;
    end
    if (ts_byp) begin
      next_zone = CTZ_ZC_NORMAL;
    end else if (sense.bias_short) begin
      next_zone = CTZ_ZC_SHORT;
    end else if (otg_want && sense.otg_cold) begin
      next_zone = CTZ_ZC_OTG_COLD;
    end else if (otg_want && sense.otg_hot) begin
      next_zone = CTZ_ZC_OTG_HOT;
    end else begin
      case (sense.zone)
        CTZ_Z_COLD, CTZ_Z_HOT: next_zone = CTZ_ZC_COLDHOT;
        CTZ_Z_PRECOOL, CTZ_Z_COOL: next_zone = CTZ_ZC_COOL;
        CTZ_Z_PREWARM, CTZ_Z_WARM: next_zone = CTZ_ZC_WARM;
        default: next_zone = CTZ_ZC_NORMAL;
      endcase
    end
    // blink on a fault or OTG suspend, pull low while charging, release otherwise
    if ((ctrl[CTZ_CTRL_CHG_EN] && chg_stage && chg_fault) || otg_suspend) begin
      next_stat_oe = !blink;
    end else begin
      next_stat_oe = charge_on;
    end
  end

  // register bus decode: writes land in the data phase
  always_comb begin
    addr_ok = (haddr[7:0] <= CTZ_STAT_OFS) && (haddr[31:8] == 24'h000000)
      && (haddr[1:0] == 2'h0);
    rd_go = hsel && hready && htrans[1] && !hwrite && addr_ok;
    wr_go = hsel && hready && htrans[1] && hwrite && addr_ok;
    stat_word = '0;
    stat_word[CTZ_STAT_PHASE +: 2] = charge_phase_code;
    stat_word[CTZ_STAT_SRC +: 3] = input_source_code;
    stat_word[CTZ_STAT_ZONE +: 3] = temp_zone_code;
    stat_word[CTZ_STAT_EXP] = ctrl[CTZ_CTRL_TMR_EN] && any_expired;
    stat_word[CTZ_STAT_ZFLAG] = temp_zone_flag;
    stat_word[CTZ_STAT_XFLAG] = timer_expiry_latch;
    stat_word[CTZ_STAT_PERMIL +: 10] = current_permille;
    next_hrdata = hrdata;
    if (rd_go) begin
      case (haddr[7:0])
        CTZ_CTRL_OFS: next_hrdata = {25'h0000000, ctrl};
        CTZ_FOLD_OFS: next_hrdata = {22'h000000, fold};
        CTZ_TLEN_OFS: next_hrdata = {29'h00000000, tlen};
        default: next_hrdata = stat_word;
      endcase
    end else if (hready) begin
      next_hrdata = '0;
    end
    next_wr_pend = hready ? wr_go : wr_pend;
    next_wr_addr = hready ? haddr[7:0] : wr_addr;
    next_ctrl = ctrl;
    next_fold = fold;
    next_tlen = tlen;
    next_zflag = temp_zone_flag;
    next_xflag = timer_expiry_latch;
    if (wr_pend) begin
      case (wr_addr)
        CTZ_CTRL_OFS: next_ctrl = hwdata[6:0];
        CTZ_FOLD_OFS: next_fold = hwdata[9:0];
        CTZ_TLEN_OFS: next_tlen = hwdata[2:0];
        default: begin
          // write one to clear
          if (hwdata[CTZ_STAT_ZFLAG]) begin
            next_zflag = 1'b0;
          end
          if (hwdata[CTZ_STAT_XFLAG]) begin
            next_xflag = 1'b0;
          end
        end
      endcase
    end
    // a new event beats a clear in the same cycle
    if (next_zone != temp_zone_code) begin
      next_zflag = 1'b1;
    end
    // rising edge only, so a clear sticks while expiry holds
    next_exp_prev = stat_word[CTZ_STAT_EXP];
    if (stat_word[CTZ_STAT_EXP] && !exp_prev) begin
      next_xflag = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTZ_CTRL_RST;
      fold <= CTZ_FOLD_RST;
      tlen <= CTZ_TLEN_RST;
      charge_phase_code <= 2'h0;
      input_source_code <= CTZ_SRC_NONE;
      temp_zone_code <= CTZ_ZC_NORMAL;
      temp_zone_flag <= 1'b0;
      timer_expiry_latch <= 1'b0;
      exp_prev <= 1'b0;
      done <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      half_cnt <= '0;
      half_tick <= 1'b0;
      sec_tick <= 1'b0;
      blink <= 1'b0;
      charge_on <= 1'b0;
      current_permille <= 10'h000;
      boost_on <= 1'b0;
      high_side_switch <= 1'b0;
      accessory_power_good <= 1'b0;
      bias_switch_on <= 1'b0;
      stat_out <= 1'b0;
      stat_oe <= 1'b0;
    end else if (ce) begin
      ctrl <= next_ctrl;
      fold <= next_fold;
      tlen <= next_tlen;
      charge_phase_code <= next_phase;
      input_source_code <= next_src;
      temp_zone_code <= next_zone;
      temp_zone_flag <= next_zflag;
      timer_expiry_latch <= next_xflag;
      exp_prev <= next_exp_prev;
      done <= next_done;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      half_cnt <= next_half_cnt;
      half_tick <= next_half_tick;
      sec_tick <= next_sec_tick;
      blink <= next_blink;
      charge_on <= next_charge_on;
      current_permille <= next_permille;
      boost_on <= next_boost_on;
      high_side_switch <= next_hss;
      accessory_power_good <= next_apg;
      bias_switch_on <= next_bias;
      stat_oe <= next_stat_oe;
    end
  end
endmodule : ctz_top
`default_nettype wire

// *** logic/ctz_pkg.sv ***
`default_nettype none
package ctz_pkg;
  // register byte offsets
  localparam logic [7:0] CTZ_CTRL_OFS = 8'h00;
  localparam logic [7:0] CTZ_FOLD_OFS = 8'h04;
  localparam logic [7:0] CTZ_TLEN_OFS = 8'h08;
  localparam logic [7:0] CTZ_STAT_OFS = 8'h0c;
  // control fields
  localparam int CTZ_CTRL_TMR_EN = 0;
  localparam int CTZ_CTRL_HALF_EN = 1;
  localparam int CTZ_CTRL_TS_BYP = 2;
  localparam int CTZ_CTRL_TERM_EN = 3;
  localparam int CTZ_CTRL_CHG_EN = 4;
  localparam int CTZ_CTRL_OTG_EN = 5;
  localparam int CTZ_CTRL_BYP_EN = 6;
  localparam logic [6:0] CTZ_CTRL_RST = 7'h19;
  // fold-back fields, two bits each
  localparam int CTZ_FOLD_PRECOOL = 0;
  localparam int CTZ_FOLD_COOL = 2;
  localparam int CTZ_FOLD_PREWARM = 4;
  localparam int CTZ_FOLD_WARM = 6;
  localparam int CTZ_FOLD_RATE = 8;
  localparam logic [9:0] CTZ_FOLD_RST = 10'h0ff;
  // timer length fields
  localparam int CTZ_TLEN_FAST = 0;
  localparam int CTZ_TLEN_PRE = 2;
  localparam logic [2:0] CTZ_TLEN_RST = 3'h1;
  // status fields
  localparam int CTZ_STAT_PHASE = 0;
  localparam int CTZ_STAT_SRC = 2;
  localparam int CTZ_STAT_ZONE = 5;
  localparam int CTZ_STAT_EXP = 8;
  localparam int CTZ_STAT_ZFLAG = 9;
  localparam int CTZ_STAT_XFLAG = 10;
  localparam int CTZ_STAT_PERMIL = 16;
  // timing
  localparam int CTZ_CLK_HZ = 25_000_000;
  localparam int CTZ_HALF_SEC_CYC = CTZ_CLK_HZ / 2;
  localparam int CTZ_TRICKLE_SEC = 3600;
  localparam logic [16:0] CTZ_FAST_SEC_0 = 17'h04650;
  localparam logic [16:0] CTZ_FAST_SEC_1 = 17'h08ca0;
  localparam logic [16:0] CTZ_FAST_SEC_2 = 17'h0d2f0;
  localparam logic [16:0] CTZ_FAST_SEC_3 = 17'h11940;
  localparam logic [16:0] CTZ_PRE_SEC_0 = 17'h00708;
  localparam logic [16:0] CTZ_PRE_SEC_1 = 17'h01c20;
  // zone and source codes
  localparam logic [2:0] CTZ_ZC_NORMAL = 3'h0;
  localparam logic [2:0] CTZ_ZC_OTG_COLD = 3'h1;
  localparam logic [2:0] CTZ_ZC_OTG_HOT = 3'h2;
  localparam logic [2:0] CTZ_ZC_SHORT = 3'h3;
  localparam logic [2:0] CTZ_ZC_COLDHOT = 3'h4;
  localparam logic [2:0] CTZ_ZC_COOL = 3'h5;
  localparam logic [2:0] CTZ_ZC_WARM = 3'h6;
  localparam logic [2:0] CTZ_SRC_OTG = 3'h7;
  localparam logic [2:0] CTZ_SRC_NONE = 3'h0;
  // fold-back settings and result in tenths of a percent
  localparam logic [1:0] CTZ_FB_SUSPEND = 2'h0;
  localparam logic [1:0] CTZ_FB_20 = 2'h1;
  localparam logic [1:0] CTZ_FB_40 = 2'h2;
  localparam logic [9:0] CTZ_PM_FULL = 10'h3e8;

  typedef enum logic [2:0] {
    CTZ_Z_COLD = 3'b000, CTZ_Z_PRECOOL = 3'b001, CTZ_Z_COOL = 3'b010,
    CTZ_Z_NORMAL = 3'b011, CTZ_Z_PREWARM = 3'b100, CTZ_Z_WARM = 3'b101,
    CTZ_Z_HOT = 3'b110
  } ctz_zone_type;

  typedef enum logic [2:0] {
    CTZ_S_IDLE = 3'b000, CTZ_S_TRICKLE = 3'b001, CTZ_S_PRE = 3'b010,
    CTZ_S_FAST = 3'b011, CTZ_S_CV = 3'b100, CTZ_S_TOPOFF = 3'b101
  } ctz_stage_type;

  // comparator results
  typedef struct packed {
    ctz_zone_type zone;
    logic otg_cold;
    logic otg_hot;
    logic bias_short;
    logic measuring;
  } ctz_sense_type;
endpackage : ctz_pkg
`default_nettype wire

// *** logic/ctz_timer.sv ***
`default_nettype none
module ctz_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic sec_tick,
  input wire logic run,
  input wire logic half,
  input wire logic clear,
  input wire logic [16:0] length,
  output logic expired
);
  import ctz_pkg::*;
  logic [16:0] count;
  logic [16:0] next_count;
  logic odd;
  logic next_odd;
  logic next_expired;

  // half rate drops every other second
  always_comb begin
    next_count = count;
    next_odd = odd;
    next_expired = expired;
    if (clear) begin
      next_count = '0;
      next_odd = 1'b0;
      next_expired = 1'b0;
    end else if (run && sec_tick && !expired) begin
      next_odd = half ? !odd : 1'b0;
      if (!half || odd) begin
        next_count = count + 17'h00001;
      end
      if (count >= length) begin
        next_expired = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      odd <= 1'b0;
      expired <= 1'b0;
    end else if (ce) begin
      count <= next_count;
      odd <= next_odd;
      expired <= next_expired;
    end
  end
endmodule : ctz_timer
`default_nettype wire

// *** logic/ctz_foldback.sv ***
`default_nettype none
module ctz_foldback (
  input wire logic [1:0] setting,
  input wire logic [1:0] rate,
  output logic [9:0] permille
);
  import ctz_pkg::*;
  logic [9:0] base;

  // scale by 1/1, 1/2, 1/4, 1/6 of the 1C figure
  always_comb begin
    base = (setting == CTZ_FB_40) ? 10'h190 : 10'h0c8;
    case (setting)
      CTZ_FB_SUSPEND: permille = 10'h000;
      CTZ_FB_20, CTZ_FB_40: begin
        case (rate)
          2'h0: permille = base;
          2'h1: permille = base >> 1;
          2'h2: permille = base >> 2;
          2'h3: permille = (setting == CTZ_FB_40) ? 10'h042 : 10'h021;
          default: permille = base;
        endcase
      end
      default: permille = CTZ_PM_FULL;
    endcase
  end
endmodule : ctz_foldback
`default_nettype wire

// *** tb/ctz_monitor.sv ***
`default_nettype none
module ctz_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire ctz_pkg::ctz_sense_type sense_in,
  input wire logic charge_on,
  input wire logic [9:0] current_permille,
  input wire logic high_side_switch,
  input wire logic accessory_power_good,
  input wire logic bias_switch_on,
  input wire logic stat_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import ctz_pkg::*;
  // one domain; outputs trail the sensed inputs by two edges, hence depth 2
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_otg_out;
    $past(sense_in.otg_cold, 2) || $past(sense_in.otg_hot, 2);
  endsequence
  sequence s_short;
    $past(sense_in.bias_short, 2);
  endsequence
  a_bias_idle: assert property (!$past(sense_in.measuring, 2) |-> !bias_switch_on)
    else $error("bias switch closed with no measurement");
  a_short_open: assert property (s_short |-> !bias_switch_on)
    else $error("bias switch closed onto a short");
  a_otg_window: assert property (s_otg_out |->
    !high_side_switch && !accessory_power_good)
    else $error("accessory path live outside otg window");
  a_cold_hot: assert property ($past(sense_in.zone, 2) inside {CTZ_Z_COLD, CTZ_Z_HOT}
    |-> !charge_on)
    else $error("charging in cold or hot zone");
  a_zero_idle: assert property (!charge_on |-> current_permille == 10'h000)
    else $error("current reported while not charging");
  a_fold_max: assert property (current_permille <= CTZ_PM_FULL)
    else $error("current above full scale");
  a_read_idle: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  a_stat_low: assert property (stat_out == 1'b0)
    else $error("status pin driven high");
endmodule // ctz_monitor
`default_nettype wire

// *** tb/ctz_host_model.sv ***
`default_nettype none
module ctz_host_model (
  input wire logic hclk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // bus idle from time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // single word transfer; entered just after a rising edge, never assumes a latency
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
endmodule // ctz_host_model
`default_nettype wire

// *** tb/tb_charge_temp_zone_safety_timer.sv ***
`default_nettype none
module tb_charge_temp_zone_safety_timer;
  timeunit 1ns;
  timeprecision 1ns;
  import ctz_pkg::*;
  localparam int SEC = 8; // second tick with a half second of 4 cycles
  localparam int P20[4] = '{200, 100, 50, 33};
  localparam int P40[4] = '{400, 200, 100, 66};
  logic hclk, hresetn, hsel, hwrite, hready_o, hresp, charge_on, boost_on;
  logic hss, apg, bias_on, stat_out, stat_oe, term_detect, otg_ready, pmid_ok;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [9:0] permille;
  ctz_sense_type sense;
  ctz_stage_type stage;
  int bad_count, compares, cycles;

  ctz_top #(.HALF_SEC_CYC(4)) u_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready_o), .hrdata(hrdata), .hreadyout(hready_o), .hresp(hresp),
    .sense_in(sense), .stage_in(stage), .term_detect(term_detect), .otg_ready(otg_ready),
    .pmid_in_range(pmid_ok), .adapter_source_code(3'h0), .charge_on(charge_on),
    .current_permille(permille), .boost_on(boost_on), .high_side_switch(hss),
    .accessory_power_good(apg), .bias_switch_on(bias_on), .stat_out(stat_out), .stat_oe(stat_oe));
  ctz_host_model u_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready_o), .hrdata(hrdata));

  // free running clock, 40 ns period
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic test_done;
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // second tick phase is unknown, so three ticks of slack either way
  task automatic chk_len(input string what, input int exp, input int got);
    chk(what, exp, (got > exp - 24 && got < exp + 24) ? exp : got);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    u_host.xfer(1'b1, {24'h0, a}, d, unused);
  endtask
  task automatic rd(input logic [7:0] a);
    u_host.xfer(1'b0, {24'h0, a}, 32'h0, rdat);
  endtask
  // two edges of pipeline plus margin
  task automatic settle;
    repeat (4) @(posedge hclk);
  endtask
  task automatic run_to_expiry(output int n);
    n = 0;
    while (charge_on === 1'b1 && n < 40000) begin
      @(posedge hclk);
      n++;
    end
  endtask
  task automatic t_regs;
    rd(CTZ_CTRL_OFS);
    chk("ctrl reset", {25'h0, CTZ_CTRL_RST}, rdat);
    rd(CTZ_FOLD_OFS);
    chk("fold reset", {22'h0, CTZ_FOLD_RST}, rdat);
    rd(CTZ_TLEN_OFS);
    chk("tlen reset", {29'h0, CTZ_TLEN_RST}, rdat);
    wr(8'h10, 32'hffffffff);
    rd(8'h10);
    chk("unmapped", 32'h0, rdat);
  endtask
  task automatic t_fold;
    logic [9:0] e;
    logic was;
    int tg;
    stage <= CTZ_S_FAST;
    sense.zone <= CTZ_Z_COOL;
    for (int s = 0; s < 4; s++) begin
      for (int r = 0; r < 4; r++) begin
        wr(CTZ_FOLD_OFS, {22'h0, r[1:0], 4'hf, s[1:0], 2'h3});
        settle();
        e = (s == 0) ? 10'h0 : (s == 3) ? CTZ_PM_FULL : 10'(s == 1 ? P20[r] : P40[r]);
        chk("permille", {22'h0, e}, {22'h0, permille});
      end
    end
    // cool zone suspended: idle phase and a blinking status pin
    wr(CTZ_FOLD_OFS, 32'h0f3);
    settle();
    rd(CTZ_STAT_OFS);
    chk("phase", 32'h0, {30'h0, rdat[1:0]});
    tg = 0;
    was = stat_oe;
    for (int i = 0; i < 20; i++) begin
      @(posedge hclk);
      if (stat_oe !== was) tg++;
      was = stat_oe;
    end
    chk("blink", 32'h1, {31'h0, tg >= 4});
    wr(CTZ_FOLD_OFS, 32'h0ff);
    sense.zone <= CTZ_Z_NORMAL;
  endtask
  task automatic otg_up;
    int n;
    n = 0;
    while (hss !== 1'b1 && n < 500) begin
      @(posedge hclk);
      n++;
    end
    rd(CTZ_STAT_OFS);
    chk("otg src", {29'h0, CTZ_SRC_OTG}, {29'h0, rdat[4:2]});
    chk("otg zone", 32'h0, {29'h0, rdat[7:5]});
  endtask
  task automatic t_otg;
    wr(CTZ_CTRL_OFS, 32'h61);
    stage <= CTZ_S_IDLE;
    otg_ready <= 1'b1;
    pmid_ok <= 1'b1;
    otg_up();
    for (int k = 0; k < 2; k++) begin
      wr(CTZ_STAT_OFS, 32'h200);
      sense.otg_cold <= (k == 0);
      sense.otg_hot <= (k == 1);
      settle();
      chk("hss off", 32'h0, {31'h0, hss});
      chk("pgood off", 32'h0, {31'h0, apg});
      rd(CTZ_STAT_OFS);
      chk("susp src", 32'h0, {29'h0, rdat[4:2]});
      chk("susp zone", k + 1, {29'h0, rdat[7:5]});
      chk("zone flag", 32'h1, {31'h0, rdat[9]});
      sense.otg_cold <= 1'b0;
      sense.otg_hot <= 1'b0;
      otg_up();
    end
    // boost path instead of bypass
    wr(CTZ_CTRL_OFS, 32'h21);
    settle();
    chk("boost on", 32'h1, {31'h0, boost_on});
    otg_ready <= 1'b0;
  endtask
  task automatic t_bias;
    wr(CTZ_CTRL_OFS, {25'h0, CTZ_CTRL_RST});
    stage <= CTZ_S_FAST;
    sense.measuring <= 1'b0;
    settle();
    chk("bias idle", 32'h0, {31'h0, bias_on});
    sense.measuring <= 1'b1;
    settle();
    chk("bias on", 32'h1, {31'h0, bias_on});
    sense.bias_short <= 1'b1;
    settle();
    chk("bias short", 32'h0, {31'h0, bias_on});
    chk("short chg", 32'h0, {31'h0, charge_on});
    rd(CTZ_STAT_OFS);
    chk("short zone", {29'h0, CTZ_ZC_SHORT}, {29'h0, rdat[7:5]});
    // thermistor ignored: short and cool zone no longer count
    wr(CTZ_CTRL_OFS, 32'h1d);
    sense.measuring <= 1'b0;
    sense.zone <= CTZ_Z_COOL;
    settle();
    rd(CTZ_STAT_OFS);
    chk("bypass zone", 32'h0, {29'h0, rdat[7:5]});
    chk("bypass chg", 32'h1, {31'h0, charge_on});
    sense.bias_short <= 1'b0;
    sense.zone <= CTZ_Z_NORMAL;
  endtask
  task automatic t_timer;
    int n;
    wr(CTZ_TLEN_OFS, 32'h0);
    wr(CTZ_CTRL_OFS, 32'h18);
    stage <= CTZ_S_PRE;
    repeat (16000) @(posedge hclk);
    chk("timers off", 32'h1, {31'h0, charge_on});
    wr(CTZ_CTRL_OFS, 32'h19);
    repeat (5000) @(posedge hclk);
    sense.zone <= CTZ_Z_COLD;
    repeat (2000) @(posedge hclk);
    sense.zone <= CTZ_Z_NORMAL;
    settle();
    run_to_expiry(n);
    chk_len("pre length", 1800 * SEC, 5004 + n);
    rd(CTZ_STAT_OFS);
    chk("expiry ind", 32'h1, {31'h0, rdat[8]});
    chk("expiry latch", 32'h1, {31'h0, rdat[10]});
    // cool zone at 20 percent with doubling on
    wr(CTZ_CTRL_OFS, 32'h0b);
    wr(CTZ_FOLD_OFS, 32'h0f7);
    sense.zone <= CTZ_Z_COOL;
    wr(CTZ_CTRL_OFS, 32'h1b);
    settle();
    run_to_expiry(n);
    chk_len("half length", 2 * 1800 * SEC, n + 4);
    // no timers and no termination: charging holds
    wr(CTZ_CTRL_OFS, 32'h00);
    wr(CTZ_FOLD_OFS, 32'h0ff);
    wr(CTZ_CTRL_OFS, 32'h10);
    sense.zone <= CTZ_Z_NORMAL;
    stage <= CTZ_S_CV;
    term_detect <= 1'b1;
    repeat (100) @(posedge hclk);
    chk("no term", 32'h1, {31'h0, charge_on});
  endtask
  // main sequence
  initial begin
    hresetn = 1'b0;
    sense = '{CTZ_Z_NORMAL, 1'b0, 1'b0, 1'b0, 1'b1};
    stage = CTZ_S_IDLE;
    term_detect = 1'b0;
    otg_ready = 1'b0;
    pmid_ok = 1'b0;
    bad_count = 0;
    compares = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_fold();
    t_otg();
    t_bias();
    t_timer();
    test_done();
  end
  // hang guard, well above the roughly 62k cycles needed
  initial begin
    cycles = 0;
    while (cycles < 90000) begin
      @(posedge hclk);
      cycles++;
    end
    bad_count++;
    test_done();
  end
endmodule // tb_charge_temp_zone_safety_timer

bind ctz_top ctz_monitor u_mon (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .sense_in, .charge_on, .current_permille, .high_side_switch,
  .accessory_power_good, .bias_switch_on, .stat_out);
`default_nettype wire
